/* shared/cc_timer_pkg.sv */
// Constants, register map and carrier types of the capture/compare timer.
// Assumes a byte-wide register port on the timer clock.
package cc_timer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h12;
  localparam logic [7:0] OFS_FLAGS = 8'h13;
  localparam logic [7:0] OFS_CAP_HI = 8'h14;
  localparam logic [7:0] OFS_CAP_LO = 8'h15;
  localparam logic [7:0] OFS_MATCH_HI = 8'h16;
  localparam logic [7:0] OFS_MATCH_LO = 8'h17;
  localparam logic [7:0] OFS_CNT_HI = 8'h18;
  localparam logic [7:0] OFS_CNT_LO = 8'h19;
  localparam logic [7:0] OFS_QUIET_HI = 8'h1A;
  localparam logic [7:0] OFS_QUIET_LO = 8'h1B;

  // Control register fields.
  localparam int BIT_CAP_IE = 7;
  localparam int BIT_MATCH_IE = 6;
  localparam int BIT_OVF_IE = 5;
  localparam int BIT_EDGE_SEL = 1;

  // Flag register fields.
  localparam int BIT_CAP_FLAG = 7;
  localparam int BIT_MATCH_FLAG = 6;
  localparam int BIT_OVF_FLAG = 5;

  // Counter and timing.
  localparam logic [15:0] CNT_PRESET = 16'hFFFC;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam int PRESCALE_DIV = 4;
  localparam int CNT_PERIOD_CYCLES = 262144;
  localparam int STARTUP_CYCLES_DEF = 4064;
  localparam int CLK_PERIOD_NS = 10;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] start_cnt;
    logic started;
    logic [1:0] pre;
    logic [15:0] cnt;
    logic [7:0] cnt_lo_latch;
    logic cnt_latched;
    logic [7:0] quiet_lo_latch;
    logic quiet_latched;
    logic pin_d;
    logic pin_valid;
    logic cap_hold;
    logic [15:0] match_val;
    logic match_hold;
    logic capture_irq_enable;
    logic match_irq_enable;
    logic overflow_irq_enable;
    logic capture_edge_select;
    logic capture_flag;
    logic match_flag;
    logic overflow_flag;
    logic cap_arm;
    logic match_arm;
    logic ovf_arm;
    logic [7:0] rdata;
    logic irq;
  } timer_state_t;

endpackage

/* logic/cc_timer.sv */
// Free-running 16-bit capture/compare timer with byte-wide register port.
// Assumes the capture pin and the register port are synchronous to ref_clk.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns

module cc_timer #(
  parameter int STARTUP_CYCLES = cc_timer_pkg::STARTUP_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire cc_timer_pkg::bus_req_t bus_req,
  input wire logic capture_input_pin,
  output logic [7:0] rdata,
  output logic timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State and decode.

  cc_timer_pkg::timer_state_t st_reg;
  cc_timer_pkg::timer_state_t st_next;
  logic [15:0] cap_reg;
  logic [15:0] cap_next;
  logic tick;
  logic [15:0] cnt_inc;
  logic pin_rise;
  logic pin_fall;
  logic cap_edge;
  logic rd_ctrl;
  logic rd_flags;
  logic rd_cap_hi;
  logic rd_cap_lo;
  logic rd_m_hi;
  logic rd_m_lo;
  logic rd_cnt_hi;
  logic rd_cnt_lo;
  logic rd_q_hi;
  logic rd_q_lo;
  logic rd_none;
  logic wr_ctrl;
  logic wr_m_hi;
  logic wr_m_lo;
  logic ovf_set;
  logic ovf_clr;
  logic cap_clr;
  logic match_set;
  logic match_clr;
  logic [7:0] rd_mux;

  assign rd_ctrl = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_CTRL;
  assign rd_flags = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_FLAGS;
  assign rd_cap_hi = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_CAP_HI;
  assign rd_cap_lo = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_CAP_LO;
  assign rd_m_hi = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_MATCH_HI;
  assign rd_m_lo = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_MATCH_LO;
  assign rd_cnt_hi = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_CNT_HI;
  assign rd_cnt_lo = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_CNT_LO;
  assign rd_q_hi = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_QUIET_HI;
  assign rd_q_lo = bus_req.rd && bus_req.addr == cc_timer_pkg::OFS_QUIET_LO;
  assign rd_none = bus_req.rd && !(rd_ctrl || rd_flags || rd_cap_hi || rd_cap_lo
                   || rd_m_hi || rd_m_lo || rd_cnt_hi || rd_cnt_lo || rd_q_hi || rd_q_lo);
  // Writes to the counter, quiet, capture and flag offsets are dropped here.
  assign wr_ctrl = bus_req.wr && bus_req.addr == cc_timer_pkg::OFS_CTRL;
  assign wr_m_hi = bus_req.wr && bus_req.addr == cc_timer_pkg::OFS_MATCH_HI;
  assign wr_m_lo = bus_req.wr && bus_req.addr == cc_timer_pkg::OFS_MATCH_LO;

  ////////////////////////////////////////////////////////////////////////////
  // Counter, prescaler and events.

  // The prescaler only runs once the start-up delay is over.
  assign tick = st_reg.started && st_reg.pre == cc_timer_pkg::PRESCALE_LAST;
  assign cnt_inc = st_reg.cnt + 16'h0001;
  assign pin_rise = st_reg.pin_valid && capture_input_pin && !st_reg.pin_d;
  assign pin_fall = st_reg.pin_valid && !capture_input_pin && st_reg.pin_d;
  assign cap_edge = st_reg.capture_edge_select ? pin_rise : pin_fall;
  assign ovf_set = tick && st_reg.cnt == cc_timer_pkg::CNT_MAX;
  assign ovf_clr = rd_cnt_lo && st_reg.ovf_arm;
  assign cap_clr = rd_cap_lo && st_reg.cap_arm;
  assign match_set = tick && !st_reg.match_hold
                     && cnt_inc == st_reg.match_val;
  assign match_clr = (rd_m_lo || wr_m_lo) && st_reg.match_arm;

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  always_comb begin
    case (bus_req.addr)
      cc_timer_pkg::OFS_CTRL: begin
        rd_mux = 8'h00;
        rd_mux[cc_timer_pkg::BIT_CAP_IE] = st_reg.capture_irq_enable;
        rd_mux[cc_timer_pkg::BIT_MATCH_IE] = st_reg.match_irq_enable;
        rd_mux[cc_timer_pkg::BIT_OVF_IE] = st_reg.overflow_irq_enable;
        rd_mux[cc_timer_pkg::BIT_EDGE_SEL] = st_reg.capture_edge_select;
      end
      cc_timer_pkg::OFS_FLAGS: begin
        rd_mux = 8'h00;
        rd_mux[cc_timer_pkg::BIT_CAP_FLAG] = st_reg.capture_flag;
        rd_mux[cc_timer_pkg::BIT_MATCH_FLAG] = st_reg.match_flag;
        rd_mux[cc_timer_pkg::BIT_OVF_FLAG] = st_reg.overflow_flag;
      end
      cc_timer_pkg::OFS_CAP_HI: rd_mux = cap_reg[15:8];
      cc_timer_pkg::OFS_CAP_LO: rd_mux = cap_reg[7:0];
      cc_timer_pkg::OFS_MATCH_HI: rd_mux = st_reg.match_val[15:8];
      cc_timer_pkg::OFS_MATCH_LO: rd_mux = st_reg.match_val[7:0];
      cc_timer_pkg::OFS_CNT_HI: rd_mux = st_reg.cnt[15:8];
      cc_timer_pkg::OFS_CNT_LO: begin
        rd_mux = st_reg.cnt_latched ? st_reg.cnt_lo_latch : st_reg.cnt[7:0];
      end
      cc_timer_pkg::OFS_QUIET_HI: rd_mux = st_reg.cnt[15:8];
      cc_timer_pkg::OFS_QUIET_LO: begin
        rd_mux = st_reg.quiet_latched ? st_reg.quiet_lo_latch : st_reg.cnt[7:0];
      end
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_next = st_reg;
    cap_next = cap_reg;
    // Start-up delay: the counter sits at its preset meanwhile.
    if (!st_reg.started) begin
      st_next.start_cnt = st_reg.start_cnt + 16'h0001;
      if (st_reg.start_cnt == 16'(STARTUP_CYCLES - 1)) begin
        st_next.started = 1'b1;
      end
    end else begin
      st_next.pre = st_reg.pre + 2'h1;
    end
    // Reads move latches, arms, holds and flags, never the count itself.
    if (tick) begin
      st_next.cnt = cnt_inc;
    end
    // Main counter pair low-byte latch.
    if (rd_cnt_hi && !st_reg.cnt_latched) begin
      st_next.cnt_lo_latch = st_reg.cnt[7:0];
      st_next.cnt_latched = 1'b1;
    end
    if (rd_cnt_lo) begin
      st_next.cnt_latched = 1'b0;
    end
    // Quiet pair latch, independent of the main one and of the flags.
    if (rd_q_hi && !st_reg.quiet_latched) begin
      st_next.quiet_lo_latch = st_reg.cnt[7:0];
      st_next.quiet_latched = 1'b1;
    end
    if (rd_q_lo) begin
      st_next.quiet_latched = 1'b0;
    end
    // Capture input edge tracking.
    st_next.pin_d = capture_input_pin;
    st_next.pin_valid = 1'b1;
    // A high-byte read blocks transfers; the low read does not.
    if (rd_cap_hi) begin
      st_next.cap_hold = 1'b1;
    end
    if (rd_cap_lo) begin
      st_next.cap_hold = 1'b0;
    end
    if (cap_edge && !st_reg.cap_hold) begin
      cap_next = cnt_inc;
    end
    // Match value and compare suspension.
    if (wr_m_hi) begin
      st_next.match_val[15:8] = bus_req.wdata;
      st_next.match_hold = 1'b1;
    end
    if (wr_m_lo) begin
      st_next.match_val[7:0] = bus_req.wdata;
      st_next.match_hold = 1'b0;
    end
    if (wr_ctrl) begin
      st_next.capture_irq_enable = bus_req.wdata[cc_timer_pkg::BIT_CAP_IE];
      st_next.match_irq_enable = bus_req.wdata[cc_timer_pkg::BIT_MATCH_IE];
      st_next.overflow_irq_enable = bus_req.wdata[cc_timer_pkg::BIT_OVF_IE];
      st_next.capture_edge_select = bus_req.wdata[cc_timer_pkg::BIT_EDGE_SEL];
    end
    // A status read arms each flag that it saw set; the clearing access
    // spends the arm.
    if (rd_flags) begin
      st_next.cap_arm = st_reg.capture_flag;
      st_next.match_arm = st_reg.match_flag;
      st_next.ovf_arm = st_reg.overflow_flag;
    end
    if (ovf_clr) begin
      st_next.ovf_arm = 1'b0;
    end
    if (cap_clr) begin
      st_next.cap_arm = 1'b0;
    end
    if (match_clr) begin
      st_next.match_arm = 1'b0;
    end
    // Set wins over a clear in the same cycle so no event is lost.
    st_next.overflow_flag = ovf_set || (st_reg.overflow_flag && !ovf_clr);
    st_next.capture_flag = cap_edge || (st_reg.capture_flag && !cap_clr);
    st_next.match_flag = match_set || (st_reg.match_flag && !match_clr);
    st_next.irq = (st_next.overflow_flag && st_next.overflow_irq_enable)
                  || (st_next.capture_flag && st_next.capture_irq_enable)
                  || (st_next.match_flag && st_next.match_irq_enable);
    st_next.rdata = bus_req.rd ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.cnt <= cc_timer_pkg::CNT_PRESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // The capture value has no reset so that it survives a device reset.
  always_ff @(posedge ref_clk) begin
    cap_reg <= cap_next;
  end

  assign rdata = st_reg.rdata;
  assign timer_irq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_preset_hold: assert property (!st_reg.started |-> st_reg.cnt == 16'hFFFC)
    else $error("counter moved during start-up");
  a_count_step: assert property (tick |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("counter did not step by one");
  a_prescale_gap: assert property (tick |=> !tick [*3])
    else $error("prescaler ticked early");
  a_wrap_flag: assert property (ovf_set |=> st_reg.overflow_flag)
    else $error("wrap did not set overflow flag");
  a_ovf_clear: assert property ($fell(st_reg.overflow_flag) |-> $past(ovf_clr))
    else $error("overflow flag cleared without armed low read");
  a_quiet_keep: assert property ((rd_q_hi || rd_q_lo) && st_reg.overflow_flag
    |=> st_reg.overflow_flag)
    else $error("quiet read cleared overflow flag");
  a_low_frozen: assert property (rd_cnt_hi && !st_reg.cnt_latched
    |=> st_reg.cnt_latched && st_reg.cnt_lo_latch == $past(st_reg.cnt[7:0]))
    else $error("low byte not frozen by high read");
  a_cap_value: assert property (cap_edge && !st_reg.cap_hold
    |=> cap_reg == $past(st_reg.cnt) + 16'h0001 && st_reg.capture_flag)
    else $error("capture value or flag wrong");
  a_cap_blocked: assert property (st_reg.cap_hold |=> $stable(cap_reg))
    else $error("capture transfer while blocked");
  a_match_set: assert property (match_set |=> st_reg.match_flag)
    else $error("match did not set match flag");
  a_match_hold: assert property (st_reg.match_hold |=> !$rose(st_reg.match_flag))
    else $error("compare not suspended");
  a_irq_or: assert property (timer_irq == ((st_reg.overflow_flag && st_reg.overflow_irq_enable)
    || (st_reg.capture_flag && st_reg.capture_irq_enable)
    || (st_reg.match_flag && st_reg.match_irq_enable)))
    else $error("interrupt request not flag and enable");
  a_unmapped_zero: assert property (rd_none |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  c_capture: cover property (cap_edge && !st_reg.cap_hold);
  c_wrap_irq: cover property (ovf_set && st_reg.overflow_irq_enable);
  c_match: cover property (match_set);
  c_frozen_read: cover property (rd_cnt_hi ##[1:8] rd_cnt_lo && st_reg.cnt_latched);

endmodule

/* testbench/pin_source.sv */
// Model of the external signal source on the capture input pin.
// Assumes the bench asks for pin levels synchronously to ref_clk.
`timescale 1ns/1ns

module pin_source (
  input wire logic ref_clk,
  input wire logic level_req,
  output logic capture_input_pin
);
  // The source changes level just after an edge, as a synchronised signal would.
  initial capture_input_pin = 1'b0;
  always @(posedge ref_clk) capture_input_pin <= level_req;
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the capture/compare timer.
// Assumes the package, the timer and the pin source model are compiled first.
`timescale 1ns/1ns

module testbench;
  localparam int S = 8;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  cc_timer_pkg::bus_req_t bus_req = '0;
  logic level_req = 1'b0;
  logic capture_input_pin;
  logic [7:0] rdata;
  logic timer_irq;
  logic [7:0] d;
  logic [15:0] v;
  logic [15:0] e;
  logic [15:0] c;
  int cyc = 0;
  int fails = 0;
  int compares = 0;

  always #5 ref_clk = ~ref_clk;

  pin_source i_src (.ref_clk(ref_clk), .level_req(level_req),
    .capture_input_pin(capture_input_pin));
  cc_timer #(.STARTUP_CYCLES(S)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
    .capture_input_pin(capture_input_pin), .rdata(rdata), .timer_irq(timer_irq));

  // The edge counter restarts with reset, so cnt_at() follows every release.
  always @(posedge ref_clk) begin
    cyc <= rstn ? cyc + 1 : 0;
    if (cyc == 2000) begin
      fails++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counter value held after edge n, counting edges from reset release.
  function automatic logic [15:0] cnt_at(int n);
    return cc_timer_pkg::CNT_PRESET + 16'((n > S ? n - S : 0) / 4);
  endfunction

  task automatic wr(logic [7:0] a, logic [7:0] w);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Launches a pin change where no increment falls in the next two edges,
  // so the expected capture does not hang on the synchroniser's exact delay.
  task automatic pulse(logic lvl);
    do begin
      @(posedge ref_clk);
    end while ((cyc + 1 - S) % 4 != 1);
    level_req <= lvl;
    e = cnt_at(cyc + 1) + 16'h0001;
    repeat (6) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_count();
    rd(8'h18);
    v = cnt_at(cyc - 1);
    check("count high", d, v[15:8]);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h00);
    rd(8'h1B);
    check("count held in start-up", d, 8'hFC);
    rd(8'h00);
    check("unmapped read", d, 8'h00);
    repeat (20) @(posedge ref_clk);
    rd(8'h18);
    e = cnt_at(cyc - 1);
    check("count high again", d, e[15:8]);
    rd(8'h19);
    check("frozen low", d, v[7:0]);
    rd(8'h19);
    e = cnt_at(cyc - 1);
    check("transparent low", d, e[7:0]);
    rd(8'h13);
    check("overflow flag", d[5], 1'b1);
  endtask

  task automatic t_ovf();
    wr(8'h12, 8'h20);
    repeat (2) @(posedge ref_clk);
    check("overflow request", timer_irq, 1'b1);
    rd(8'h1A);
    v = cnt_at(cyc - 1);
    repeat (8) @(posedge ref_clk);
    rd(8'h18);
    e = cnt_at(cyc - 1);
    repeat (8) @(posedge ref_clk);
    rd(8'h1B);
    check("quiet low frozen", d, v[7:0]);
    rd(8'h13);
    check("overflow kept", d[5], 1'b1);
    rd(8'h19);
    check("main low frozen", d, e[7:0]);
    rd(8'h13);
    check("overflow cleared", d[5], 1'b0);
    check("overflow request off", timer_irq, 1'b0);
  endtask

  task automatic t_capture();
    wr(8'h12, 8'h82);
    pulse(1'b1);
    c = e;
    rd(8'h13);
    check("capture flag", d[7], 1'b1);
    check("capture request", timer_irq, 1'b1);
    pulse(1'b0);
    rd(8'h14);
    check("capture high", d, c[15:8]);
    pulse(1'b1);
    rd(8'h15);
    check("capture low", d, c[7:0]);
    rd(8'h13);
    check("capture flag cleared", d[7], 1'b0);
    wr(8'h12, 8'h80);
    pulse(1'b0);
    c = e;
    rd(8'h14);
    check("falling capture high", d, c[15:8]);
    rd(8'h15);
    check("falling capture low", d, c[7:0]);
  endtask

  task automatic t_match();
    wr(8'h12, 8'h40);
    v = cnt_at(cyc) + 16'h0008;
    wr(8'h16, v[15:8]);
    rd(8'h13);
    wr(8'h17, v[7:0]);
    rd(8'h13);
    check("match flag cleared", d[6], 1'b0);
    wr(8'h16, v[15:8]);
    repeat (60) @(posedge ref_clk);
    rd(8'h13);
    check("match suspended", d[6], 1'b0);
    v = cnt_at(cyc) + 16'h0004;
    wr(8'h16, v[15:8]);
    wr(8'h17, v[7:0]);
    repeat (24) @(posedge ref_clk);
    rd(8'h13);
    check("match flag", d[6], 1'b1);
    check("match request", timer_irq, 1'b1);
    rd(8'h17);
    check("match low readback", d, v[7:0]);
    rd(8'h13);
    check("match flag read clear", d[6], 1'b0);
    check("match request off", timer_irq, 1'b0);
  endtask

  task automatic t_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    // The high and low capture reads follow each other with nothing between.
    rd(8'h14);
    check("capture high kept", d, c[15:8]);
    rd(8'h15);
    check("capture low kept", d, c[7:0]);
    rd(8'h19);
    check("count preset again", d, 8'hFC);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_count();
    t_ovf();
    t_capture();
    t_match();
    t_reset();
    conclude();
  end
endmodule
